// File: hw/psd_params.svh
// constants for the privilege and segment decoder: register map,
// field positions and reset values
// assumes inclusion by bare name from the decoder
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// ==========================================================
// register byte offsets
`define PSD_CTRL_OFS        12'h000
`define PSD_MODE_OFS        12'h004
`define PSD_IRQ_STS_OFS     12'h008
`define PSD_IRQ_CLR_OFS     12'h00c
`define PSD_IRQ_EN_OFS      12'h010

// ==========================================================
// control register fields
`define PSD_CTRL_PRIV_LSB   0
`define PSD_CTRL_EXL_BIT    2
`define PSD_CTRL_ERL_BIT    3
`define PSD_CTRL_SX_BIT     4
`define PSD_CTRL_KX_BIT     5
`define PSD_CTRL_TAG_LSB    8
`define PSD_CTRL_K0_LSB     16

// mode register fields
`define PSD_MODE_KERN_BIT   0
`define PSD_MODE_SUP_BIT    1
`define PSD_MODE_WIDE_BIT   2

// interrupt event bits
`define PSD_EV_ADDR_ERR     0
`define PSD_EV_TLB_MISS     1
`define PSD_EV_RESV_HIT     2

// ==========================================================
// reset values: kernel mode with error level set, as after power-up
`define PSD_PRIV_RST        2'b00
`define PSD_EXL_RST         1'b0
`define PSD_ERL_RST         1'b1
`define PSD_K0_RST          3'h3

// fixed field codes and address constants
`define PSD_PRIV_SUPER      2'b01
`define PSD_PRIV_KERNEL     2'b00
`define PSD_ATTR_UNCACHED   3'h2
`define PSD_XKSEG_TOP       64'hc000_00ff_7fff_ffff

`endif

// File: hw/psd_pkg.sv
// types shared by the privilege and segment decoder and its users
// assumes psd_params.svh on the include path
package psd_pkg;

	// ==========================================================
	// segment classes
	typedef enum logic [3:0] {
		PSD_SEG_NONE    = 4'h0,
		PSD_SEG_USER    = 4'h1,
		PSD_SEG_SUP     = 4'h3,
		PSD_SEG_KPHYS   = 4'h2,
		PSD_SEG_KUNC    = 4'h6,
		PSD_SEG_KTOP    = 4'h7,
		PSD_SEG_RESV    = 4'h5,
		PSD_SEG_XKPHYS  = 4'h4,
		PSD_SEG_XKSEG   = 4'hc
	} psd_seg_e;

	// ==========================================================
	// pipeline request, tlb entry and decode result
	typedef struct packed {
		logic        valid;
		logic [63:0] vaddr;
	} psd_req_s;

	typedef struct packed {
		logic        valid;
		logic [27:0] vpn;
		logic        global;
		logic [7:0]  tag;
		logic [2:0]  attr;
	} psd_tlb_s;

	typedef struct packed {
		logic        valid;
		psd_seg_e    segment;
		logic        kernel_mode;
		logic        super_mode;
		logic        mapped;
		logic        uncached;
		logic [2:0]  cache_attr;
		logic [7:0]  tag;
		logic        addr_err;
		logic        tlb_miss;
		logic        ext_refill;
		logic [35:0] paddr;
	} psd_res_s;

endpackage

// File: hw/psd_decode.sv
// privilege-mode and virtual-address segment decoder with apb registers
// assumes one clock pclk; pipeline and tlb inputs are on that clock
`timescale 1ns/1ns
`include "psd_params.svh"

// Notes on behaviour
// - supervisor when level 01, no exl, erl
// - sx picks 32/64 segments and refill handler
// - supervisor refs mapped, cacheability from tlb
// - 32-bit supervisor: bit31 clear is user, tagged
// - 32-bit supervisor: top bits 110 mapped supervisor
// - 64-bit supervisor: 01 is current supervisor segment
// - 64-bit supervisor: 00 is supervisor-user segment
// - 64-bit supervisor: 11 is the 32-bit supervisor segment, sign-extended
// - 32-bit addressing needs sign-extended upper bits
// - kernel when level 00, exl or erl
// - kx picks kernel width and refill handler
// - exception enters kernel until return clears levels
// - 32-bit kernel: user and supervisor segments
// - 32-bit kernel: 100 cached, 101 uncached unmapped
// - 32-bit kernel: 111 mapped top minus hole
// - 4 MB reserved window unmapped and uncached
// - tlb hit needs vpn match, global or tag
module psd_decode (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire psd_pkg::psd_req_s req,
	input  wire psd_pkg::psd_tlb_s tlb,
	input  wire logic             exc_detect,
	input  wire logic             exc_return,
	output psd_pkg::psd_res_s     res,
	output logic                  irq
);
	import psd_pkg::*;

	// ==========================================================
	// control state
	logic [1:0]  priv_r;
	logic        exl_r;
	logic        erl_r;
	logic        sx_r;
	logic        kx_r;
	logic [7:0]  tag_r;
	logic [2:0]  k0_r;
	logic [2:0]  irq_sts_r;
	logic [2:0]  irq_en_r;
	psd_res_s    res_r;

	// ==========================================================
	// apb decode; zero wait states, unmapped offsets answer with error
	wire         apb_acc   = psel & penable;
	wire         apb_wr    = apb_acc & pwrite;
	wire         sel_ctrl  = (paddr == `PSD_CTRL_OFS);
	wire         sel_mode  = (paddr == `PSD_MODE_OFS);
	wire         sel_sts   = (paddr == `PSD_IRQ_STS_OFS);
	wire         sel_clr   = (paddr == `PSD_IRQ_CLR_OFS);
	wire         sel_en    = (paddr == `PSD_IRQ_EN_OFS);
	wire         sel_any   = sel_ctrl | sel_mode | sel_sts | sel_clr | sel_en;
	wire         wr_ctrl   = apb_wr & sel_ctrl;
	wire         wr_clr    = apb_wr & sel_clr;
	wire         wr_en     = apb_wr & sel_en;

	// ==========================================================
	// mode derivation from the privilege bits
	// supervisor mode
	wire         mode_sup  = (priv_r == `PSD_PRIV_SUPER) & ~exl_r & ~erl_r;
	wire         mode_kern = (priv_r == `PSD_PRIV_KERNEL) | exl_r | erl_r;
	// width and refill handler per mode; user mode is not decoded
	wire         wide      = (mode_sup & sx_r) | (mode_kern & kx_r);

	// register read mux
	wire [31:0]  ctrl_rd   = {13'h0, k0_r, tag_r, 2'b00, kx_r, sx_r, erl_r, exl_r, priv_r};
	wire [31:0]  mode_rd   = {29'h0, wide, mode_sup, mode_kern};
	wire [31:0]  rd_mux    = sel_ctrl ? ctrl_rd :
	                         sel_mode ? mode_rd :
	                         sel_sts  ? {29'h0, irq_sts_r} :
	                         sel_en   ? {29'h0, irq_en_r} : 32'h0;

	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~sel_any;
	assign prdata  = (apb_acc & ~pwrite) ? rd_mux : 32'h0;

	// ==========================================================
	// address field views
	wire [63:0]  va        = req.vaddr;
	wire [2:0]   top3      = va[31:29];
	wire [1:0]   region    = va[63:62];
	// upper half must copy bit 31 in 32-bit addressing
	wire         sext_ok   = (va[63:32] == {32{va[31]}});
	wire         hi40_zero = (va[61:40] == 22'h0);
	wire         compat    = (va[61:31] == {31{1'b1}});
	// reserved 4 MB hole, in both widths once sign-extended
	wire         resv_win  = sext_ok & (va[31:22] == 10'h3fc);

	// ==========================================================
	// supervisor segment classification
	psd_seg_e    sup_seg;
	logic        sup_err;
	always_comb begin
		sup_seg = PSD_SEG_NONE;
		sup_err = 1'b0;
		if (!sx_r) begin
			if (!sext_ok)
				sup_err = 1'b1;
			else if (!va[31])
				sup_seg = PSD_SEG_USER;
			else if (top3 == 3'b110)
				sup_seg = PSD_SEG_SUP;
			else
				sup_err = 1'b1;
		end else begin
			case (region)
				2'b00: begin
					sup_seg = PSD_SEG_USER;
					sup_err = ~hi40_zero;
				end
				2'b01: begin
					sup_seg = PSD_SEG_SUP;
					sup_err = ~hi40_zero;
				end
				2'b11: begin
					sup_seg = PSD_SEG_SUP;
					sup_err = ~(compat & (top3 == 3'b110));
				end
				default: begin
					sup_seg = PSD_SEG_NONE;
					sup_err = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// kernel segment classification; 32-bit form also serves
	// the compatibility segments at the top of the 64-bit space
	psd_seg_e    k32_seg;
	psd_seg_e    kern_seg;
	logic        kern_err;
	always_comb begin
		case (top3)
			3'b000, 3'b001, 3'b010, 3'b011: k32_seg = PSD_SEG_USER;
			3'b100:  k32_seg = PSD_SEG_KPHYS;
			3'b101:  k32_seg = PSD_SEG_KUNC;
			3'b110:  k32_seg = PSD_SEG_SUP;
			default: k32_seg = resv_win ? PSD_SEG_RESV : PSD_SEG_KTOP;
		endcase
		kern_seg = k32_seg;
		kern_err = 1'b0;
		if (!kx_r) begin
			kern_err = ~sext_ok;
		end else begin
			case (region)
				2'b00: begin
					kern_seg = PSD_SEG_USER;
					kern_err = ~hi40_zero;
				end
				2'b01: begin
					kern_seg = PSD_SEG_SUP;
					kern_err = ~hi40_zero;
				end
				// physical window: only bits 58:36 are checked here
				2'b10: begin
					kern_seg = PSD_SEG_XKPHYS;
					kern_err = (va[58:36] != 23'h0);
				end
				default: begin
					kern_seg = compat ? k32_seg : PSD_SEG_XKSEG;
					kern_err = ~compat & (va > `PSD_XKSEG_TOP);
				end
			endcase
		end
	end

	// ==========================================================
	// mapping, cacheability and physical address of unmapped refs
	wire         is_kern   = mode_kern;
	psd_seg_e    seg_sel;
	logic        mapped;
	logic [2:0]  attr_sel;
	logic [35:0] pa_sel;
	always_comb begin
		seg_sel  = is_kern ? kern_seg : sup_seg;
		mapped   = 1'b1;
		attr_sel = tlb.attr;
		pa_sel   = 36'h0;
		case (seg_sel)
			// error level turns user region into a direct window
			PSD_SEG_USER: begin
				if (is_kern && erl_r) begin
					mapped   = 1'b0;
					attr_sel = `PSD_ATTR_UNCACHED;
					pa_sel   = {5'h0, va[30:0]};
				end
			end
			// cached direct window, attribute from k0 field
			PSD_SEG_KPHYS: begin
				mapped   = 1'b0;
				attr_sel = k0_r;
				pa_sel   = {7'h0, va[28:0]};
			end
			PSD_SEG_KUNC: begin
				mapped   = 1'b0;
				attr_sel = `PSD_ATTR_UNCACHED;
				pa_sel   = {7'h0, va[28:0]};
			end
			// reserved hole bypasses the tlb uncached
			PSD_SEG_RESV: begin
				mapped   = 1'b0;
				attr_sel = `PSD_ATTR_UNCACHED;
				pa_sel   = {4'h0, va[31:0]};
			end
			PSD_SEG_XKPHYS: begin
				mapped   = 1'b0;
				attr_sel = va[61:59];
				pa_sel   = va[35:0];
			end
			PSD_SEG_NONE: begin
				mapped   = 1'b0;
				attr_sel = 3'h0;
			end
			default: begin
				mapped   = 1'b1;
				attr_sel = tlb.attr;
			end
		endcase
	end

	// ==========================================================
	// tlb hit; 4 KB pages assumed, so the vpn is the address above
	// bit 11 (narrow form zero-extended to keep one comparator)
	wire         addr_err  = is_kern ? kern_err : sup_err;
	wire         narrow    = ~wide | compat;
	wire [27:0]  req_vpn   = narrow ? {8'h0, va[31:12]} : va[39:12];
	// vpn match plus global or matching tag
	wire         tlb_hit   = tlb.valid & (tlb.vpn == req_vpn) &
	                         (tlb.global | (tlb.tag == tag_r));
	wire         miss      = mapped & ~addr_err & ~tlb_hit;
	wire         resv_ev   = (seg_sel == PSD_SEG_RESV) & ~addr_err;

	// next result, one cycle after the request
	psd_res_s    res_nxt;
	always_comb begin
		res_nxt             = '0;
		res_nxt.valid       = req.valid;
		res_nxt.segment     = seg_sel;
		res_nxt.kernel_mode = mode_kern;
		res_nxt.super_mode  = mode_sup;
		res_nxt.mapped      = mapped & ~addr_err;
		res_nxt.uncached    = (attr_sel == `PSD_ATTR_UNCACHED);
		res_nxt.cache_attr  = attr_sel;
		res_nxt.tag         = mapped ? tag_r : 8'h0;
		res_nxt.addr_err    = addr_err;
		res_nxt.tlb_miss    = miss;
		// extended handler only for wide addressing
		res_nxt.ext_refill  = miss & wide;
		res_nxt.paddr       = mapped ? 36'h0 : pa_sel;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			res_r <= '0;
		else
			res_r <= res_nxt;
	end
	assign res = res_r;

	// ==========================================================
	// privilege bits; exception entry wins over return and writes
	wire         exl_nxt   = exc_detect ? 1'b1 :
	                         (exc_return & ~erl_r) ? 1'b0 :
	                         wr_ctrl ? pwdata[`PSD_CTRL_EXL_BIT] : exl_r;
	wire         erl_nxt   = exc_detect ? erl_r :
	                         exc_return ? 1'b0 :
	                         wr_ctrl ? pwdata[`PSD_CTRL_ERL_BIT] : erl_r;

	// enter kernel on exception, return clears one level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priv_r <= `PSD_PRIV_RST;
			exl_r  <= `PSD_EXL_RST;
			erl_r  <= `PSD_ERL_RST;
			sx_r   <= 1'b0;
			kx_r   <= 1'b0;
			tag_r  <= 8'h0;
			k0_r   <= `PSD_K0_RST;
		end else begin
			exl_r <= exl_nxt;
			erl_r <= erl_nxt;
			if (wr_ctrl) begin
				priv_r <= pwdata[`PSD_CTRL_PRIV_LSB +: 2];
				sx_r   <= pwdata[`PSD_CTRL_SX_BIT];
				kx_r   <= pwdata[`PSD_CTRL_KX_BIT];
				tag_r  <= pwdata[`PSD_CTRL_TAG_LSB +: 8];
				k0_r   <= pwdata[`PSD_CTRL_K0_LSB +: 3];
			end
		end
	end

	// ==========================================================
	// interrupt status: sticky, set beats a clear in the same cycle
	wire [2:0]   ev_vec;
	assign ev_vec[`PSD_EV_ADDR_ERR] = res_r.valid & res_r.addr_err;
	assign ev_vec[`PSD_EV_TLB_MISS] = res_r.valid & res_r.tlb_miss;
	assign ev_vec[`PSD_EV_RESV_HIT] = res_r.valid & (res_r.segment == PSD_SEG_RESV);
	wire [2:0]   clr_vec   = wr_clr ? pwdata[2:0] : 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_r <= 3'h0;
			irq_en_r  <= 3'h0;
		end else begin
			irq_sts_r <= (irq_sts_r & ~clr_vec) | ev_vec;
			if (wr_en)
				irq_en_r <= pwdata[2:0];
		end
	end
	assign irq = |(irq_sts_r & irq_en_r);

	// ==========================================================
	// checks on the decode
	wire         req_sup   = req.valid & (priv_r == 2'b01) & ~exl_r & ~erl_r;

	a_sup_mode_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup |=> res.super_mode & ~res.kernel_mode)
		else $error("supervisor mode not reported");

	a_kern_mode_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid & (exl_r | erl_r | priv_r == 2'b00) |=> res.kernel_mode)
		else $error("kernel mode not reported");

	a_sup_refill_sel: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup & ~sx_r |=> ~res.ext_refill)
		else $error("narrow supervisor miss sent to extended handler");

	a_kern_refill_sel: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid & mode_kern & ~erl_r & kx_r & ~tlb.valid & (va[63:62] == 2'b00) & hi40_zero
		|=> res.tlb_miss & res.ext_refill)
		else $error("wide kernel miss not sent to extended handler");

	a_sext_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup & ~sx_r & (va[63:32] != {32{va[31]}}) |=> res.addr_err & ~res.mapped)
		else $error("bad sign extension accepted");

	a_suseg_tag: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup & ~sx_r & (va[63:31] == 33'h0)
		|=> res.segment == PSD_SEG_USER && res.tag == $past(tag_r) && res.mapped)
		else $error("supervisor user segment misdecoded");

	a_sseg_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup & ~sx_r & (va[63:29] == {{33{1'b1}}, 2'b10})
		|=> res.segment == PSD_SEG_SUP && res.mapped)
		else $error("supervisor segment misdecoded");

	a_sup_stray_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup & sx_r & (va[63:62] == 2'b10) |=> res.addr_err)
		else $error("stray supervisor address accepted");

	a_exc_enter: assert property (
		@(posedge pclk) disable iff (!presetn)
		exc_detect |=> exl_r ##0 mode_kern)
		else $error("exception did not enter kernel mode");

	a_resv_window: assert property (
		@(posedge pclk) disable iff (!presetn)
		req.valid & mode_kern & ~kx_r & (va[63:22] == {{32{1'b1}}, 10'h3fc})
		|=> ~res.mapped & res.uncached ##1 irq_sts_r[`PSD_EV_RESV_HIT])
		else $error("reserved window not unmapped uncached");

	a_tlb_hit_rule: assert property (
		@(posedge pclk) disable iff (!presetn)
		req_sup & ~sx_r & (va[63:31] == 33'h0) & tlb.valid & ~tlb.global &
		(tlb.vpn == {8'h0, va[31:12]}) & (tlb.tag != tag_r) |=> res.tlb_miss)
		else $error("tag mismatch treated as hit");

endmodule // psd_decode

// File: tb/psd_core_model.sv
// pipeline and tlb stand-in that feeds the segment decoder
// assumes the bench pulses go for one cycle per request, on pclk
`timescale 1ns/1ns
module psd_core_model (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              go,
	input  wire logic [63:0]       go_va,
	input  wire psd_pkg::psd_tlb_s go_tlb,
	output psd_pkg::psd_req_s      req,
	output psd_pkg::psd_tlb_s      tlb
);
	import psd_pkg::*;

	// ==========================================================
	// issue stage
	// idle cycles flip address and entry; the request drops valid, the entry's valid bit toggles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req <= '0;
			tlb <= '0;
		end else if (go) begin
			req <= {1'b1, go_va};
			tlb <= go_tlb;
		end else begin
			req <= {1'b0, ~req.vaddr};
			tlb <= ~tlb;
		end
	end
endmodule // psd_core_model

// File: tb/psd_decode_test.sv
// self-checking bench for the privilege and segment decoder
// assumes psd_pkg compiled first and the core model in tb/
`timescale 1ns/1ns
module psd_decode_test;
	import psd_pkg::*;

	// ==========================================================
	// signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        exc_detect, exc_return, go, rd_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [63:0] go_va;
	psd_tlb_s    go_tlb, tlb;
	psd_req_s    req;
	psd_res_s    res, r;
	int          n_mismatch, num_checks;

	// ==========================================================
	// design and far side
	psd_decode psd_decode_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .tlb(tlb),
		.exc_detect(exc_detect), .exc_return(exc_return), .res(res), .irq(irq));
	psd_core_model psd_core_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
		.go_va(go_va), .go_tlb(go_tlb), .req(req), .tlb(tlb));

	// 10 MHz clock
	always #50 pclk = ~pclk;

	// ==========================================================
	// helpers
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// one apb transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd_data, exp);
	endtask

	// one decode request with a candidate entry, result captured in r
	task automatic dec(input logic [63:0] va, input logic [27:0] vpn, input logic g,
		input logic [7:0] t, input logic v);
		@(posedge pclk);
		go <= 1'b1;
		go_va <= va;
		go_tlb <= {v, vpn, g, t, 3'h3};
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1;
		r = res;
	endtask

	// valid, kernel, super, mapped, addr_err, tlb_miss, ext_refill
	function automatic logic [6:0] fl();
		return {r.valid, r.kernel_mode, r.super_mode, r.mapped, r.addr_err,
			r.tlb_miss, r.ext_refill};
	endfunction

	// exception entry (ret=0) or return (ret=1), one-cycle pulse
	task automatic exc(input logic ret);
		@(posedge pclk);
		exc_detect <= ~ret;
		exc_return <= ret;
		@(posedge pclk);
		exc_detect <= 1'b0;
		exc_return <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// watchdog at 20000 cycles; the sequence needs well under 2000
	initial begin
		#2_000_000;
		n_mismatch++;
		test_done();
	end

	// ==========================================================
	// main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, exc_detect, exc_return, go} = '0;
		{paddr, pwdata, go_va, go_tlb} = '0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset leaves kernel mode with error level set
		rd(12'h000, 32'h0003_0008);
		rd(12'h004, 32'h1);
		rd(12'h008, 32'h0);
		rd(12'h010, 32'h0);
		rd(12'h014, 32'h0);
		chk(rd_err, 1'b1);
		// error level turns the user region into an uncached direct window
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b0, 8'h00, 1'b1);
		chk(fl(), 7'h60);
		chk({r.segment, r.uncached, r.paddr}, {PSD_SEG_USER, 1'b1, 36'h012345000});
		// 32-bit supervisor, only miss events enabled
		wr(12'h000, 32'h0003_5a01);
		rd(12'h004, 32'h2);
		wr(12'h00c, 32'h7);
		wr(12'h010, 32'h2);
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h58);
		chk({r.segment, r.tag, r.cache_attr}, {PSD_SEG_USER, 8'h5a, 3'h3});
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b0, 8'h11, 1'b1);
		chk(fl(), 7'h5a);
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b1, 8'h11, 1'b1);
		chk(fl(), 7'h58);
		dec(64'hffff_ffff_c000_1000, 28'h00c0001, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h58);
		chk(r.segment, PSD_SEG_SUP);
		dec(64'hffff_ffff_8000_0000, 28'h0080000, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h54);
		dec(64'h0000_0001_0000_0000, 28'h0000000, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h54);
		// tag mismatch above left a miss, which is enabled
		rd(12'h008, 32'h3);
		chk(irq, 1'b1);
		// 64-bit supervisor, miss raises the interrupt
		wr(12'h000, 32'h0003_5a11);
		rd(12'h004, 32'h6);
		dec(64'h4000_0000_1234_5000, 28'h0012345, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h58);
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h5b);
		rd(12'h008, 32'h3);
		chk(irq, 1'b1);
		wr(12'h00c, 32'h2);
		rd(12'h008, 32'h1);
		chk(irq, 1'b0);
		wr(12'h008, 32'h7);
		rd(12'h008, 32'h1);
		dec(64'hffff_ffff_c000_1000, 28'h00c0001, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h58);
		dec(64'h8000_0000_0000_0000, 28'h0000000, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h54);
		dec(64'h0000_0100_0000_0000, 28'h0000000, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h54);
		// exception entry forces kernel, return restores supervisor
		exc(1'b0);
		rd(12'h004, 32'h1);
		rd(12'h000, 32'h0003_5a15);
		exc(1'b1);
		rd(12'h004, 32'h6);
		// 32-bit kernel
		wr(12'h000, 32'h0003_5a00);
		wr(12'h00c, 32'h7);
		rd(12'h004, 32'h1);
		dec(64'hffff_ffff_8000_1000, 28'h0080001, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h60);
		chk({r.segment, r.paddr, r.cache_attr}, {PSD_SEG_KPHYS, 36'h1000, 3'h3});
		dec(64'hffff_ffff_a000_2000, 28'h00a0002, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h60);
		chk({r.segment, r.uncached, r.paddr}, {PSD_SEG_KUNC, 1'b1, 36'h2000});
		dec(64'hffff_ffff_c000_1000, 28'h00c0001, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h68);
		chk(r.segment, PSD_SEG_SUP);
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h68);
		chk(r.segment, PSD_SEG_USER);
		dec(64'hffff_ffff_e000_1000, 28'h00e0001, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h6a);
		chk(r.segment, PSD_SEG_KTOP);
		dec(64'hffff_ffff_ff00_0000, 28'h00ff000, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h60);
		chk({r.segment, r.uncached}, {PSD_SEG_RESV, 1'b1});
		rd(12'h008, 32'h6);
		wr(12'h010, 32'h4);
		#1;
		chk(irq, 1'b1);
		// 64-bit kernel
		wr(12'h000, 32'h0003_5a20);
		rd(12'h004, 32'h5);
		dec(64'h0000_0000_1234_5000, 28'h0012345, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h6b);
		dec(64'hffff_ffff_ff00_0000, 28'h00ff000, 1'b0, 8'h5a, 1'b1);
		chk({r.segment, r.mapped}, {PSD_SEG_RESV, 1'b0});
		// physical window and mapped kernel segment of the wide space
		dec(64'h9800_0000_0000_1000, 28'h0000001, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h60);
		chk({r.segment, r.paddr, r.cache_attr}, {PSD_SEG_XKPHYS, 36'h1000, 3'h3});
		dec(64'h8000_0010_0000_0000, 28'h0000000, 1'b0, 8'h5a, 1'b0);
		chk(fl(), 7'h64);
		dec(64'hc000_0000_0000_1000, 28'h0000001, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h68);
		chk(r.segment, PSD_SEG_XKSEG);
		dec(64'hc000_0100_0000_0000, 28'h0000000, 1'b0, 8'h5a, 1'b1);
		chk(fl(), 7'h64);
		test_done();
	end
endmodule // psd_decode_test
